/* hw/iocd_cfg.svh */
/*
 Address map, field positions and reset values of the I/O card register decode.
 Assumes inclusion by the package and the decode module only.
*/
`ifndef IOCD_CFG_SVH
`define IOCD_CFG_SVH
`define IOCD_NUM_REGS 5'h14
`define IOCD_OFS_CMD 5'h00
`define IOCD_OFS_DIO 5'h01
`define IOCD_OFS_CNV 5'h02
`define IOCD_OFS_START 5'h03
`define IOCD_OFS_RDSTART 5'h04
`define IOCD_OFS_ZERO 5'h05
`define IOCD_OFS_SMPLO 5'h06
`define IOCD_OFS_SMPHI 5'h07
`define IOCD_OFS_DAC0LO 5'h08
`define IOCD_OFS_DAC0HI 5'h09
`define IOCD_OFS_DAC1LO 5'h0A
`define IOCD_OFS_DAC1HI 5'h0B
`define IOCD_OFS_CTR0 5'h0C
`define IOCD_OFS_CTR1 5'h0D
`define IOCD_OFS_CTR2 5'h0E
`define IOCD_OFS_CTRCTL 5'h0F
`define IOCD_OFS_AUXA 5'h10
`define IOCD_OFS_AUXB 5'h11
`define IOCD_OFS_AUXC 5'h12
`define IOCD_OFS_AUXCTL 5'h13
`define IOCD_BIT_CSSEL 5
`define IOCD_BIT_BUSY 7
`define IOCD_BIT_SEMODE 6
`define IOCD_UNUSED_RD 8'hFF
`define IOCD_RST_BYTE 8'h00
`define IOCD_RST_SAMPLE 12'h000
`define IOCD_RST_DAC 12'h000
`endif

/* hw/iocd_pkg.sv */
/*
 Types shared by the I/O card register decode.
 Assumes the constants header sits beside it.
*/
`include "iocd_cfg.svh"
package iocd_pkg;
	// One host I/O cycle, already qualified by the card select
	typedef struct packed {
		logic rd;
		logic wr;
		logic [4:0] ofs;
		logic [7:0] wdata;
	} iocd_host_t;
	// Strobes toward the counter and aux port devices
	typedef struct packed {
		logic rd;
		logic wr;
		logic [1:0] idx;
		logic [7:0] wdata;
	} iocd_sub_t;
endpackage

/* hw/iocd_decode.sv */
/*
 Register decode of a multifunction analog/digital I/O card on a byte-wide host I/O bus.
 Assumes host strobes are one-cycle pulses in the clk domain; converter, counter and
 aux port devices sit outside and answer on their own ports within the same cycle.
*/
// How it works
// - Twenty byte offsets; counter and aux offsets decoded as ranges
// - Offset 0: read back and write card command
// - Offset 1 read returns inputs, clears interrupt
// - Offset 2 write loads command, starts if select low
// - Any write to offset 3 starts conversion
// - Offset 4 read starts only if select high
// - Writes to offset 4 or 5 set the DAC zero flag
// - Offsets 6 and 7 read latched result bytes
// - Offsets 8/9 load DAC0, 9 updates output
// - Offsets A/B load DAC1, B updates, releases zero
// - Offsets C-E counters, F counter control
// - Offsets 10-12 aux ports, 13 aux control
// - Select bit picks read-4 or write-2 trigger
// - Result latched at conversion end, held
// - Converter status bit 7 is busy
`timescale 1ns/1ps
`default_nettype none
module iocd_decode #(
	parameter int SAMPLE_W = 12
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Host I/O cycle
	input wire iocd_pkg::iocd_host_t host,
	output logic [7:0] rdData,
	// Pins: discrete inputs and four-bit output port
	input wire logic [3:0] discIn,
	input wire logic [3:0] opIn,
	output logic [3:0] opOut,
	output logic [3:0] opOe_n,
	// Interrupt latch set by the outside
	input wire logic irqEvent,
	output logic irqLatch,
	// Converter
	input wire logic cnvEnd,
	input wire logic [SAMPLE_W-1:0] cnvData,
	input wire logic seMode,
	output logic cnvStart,
	output logic cnvBusy,
	output logic [7:0] cardCmd,
	output logic [7:0] cnvCmd,
	// DAC outputs
	output logic [11:0] dac0Out,
	output logic [11:0] dac1Out,
	output logic dacZero,
	// Counter and aux port devices
	input wire logic [7:0] ctrRdData,
	input wire logic [7:0] auxRdData,
	output iocd_pkg::iocd_sub_t ctrBus,
	output logic ctrCtlWr,
	output iocd_pkg::iocd_sub_t auxBus,
	output logic auxCtlWr
);
	import iocd_pkg::*;

	initial begin
		if (SAMPLE_W != 12) $error("iocd_decode: SAMPLE_W must be 12");
	end

	// Synchroniser stages for the pins
	logic [1:0] discS1_r;
	logic [1:0] discS2_r;
	logic [3:0] ipS1_r;
	logic [3:0] ipS2_r;
	logic [3:0] opS1_r;
	logic [3:0] opS2_r;
	// Held data: result, DAC low bytes, mode snapshot
	logic [SAMPLE_W-1:0] sample_r;
	logic [7:0] dac0Lo_r;
	logic [7:0] dac1Lo_r;
	logic [7:0] seLatch_r;
	logic [7:0] rdData_nxt;
	// Per-offset strobes, one cycle wide like the host cycle
	logic inRange;
	logic wr0;
	logic wr1;
	logic wr2;
	logic wr3;
	logic wr4;
	logic wr5;
	logic wr8;
	logic wr9;
	logic wrA;
	logic wrB;
	logic wrF;
	logic wr13;
	logic rd1;
	logic rd4;
	// Merged start request and device window hits
	logic startPulse;
	logic ctrHit;
	logic auxHit;

	// Decode of the twenty-address window
	assign inRange = host.ofs < `IOCD_NUM_REGS;
	assign wr0 = host.wr && host.ofs == `IOCD_OFS_CMD;
	assign wr1 = host.wr && host.ofs == `IOCD_OFS_DIO;
	assign wr2 = host.wr && host.ofs == `IOCD_OFS_CNV;
	assign wr3 = host.wr && host.ofs == `IOCD_OFS_START;
	assign wr4 = host.wr && host.ofs == `IOCD_OFS_RDSTART;
	assign wr5 = host.wr && host.ofs == `IOCD_OFS_ZERO;
	assign wr8 = host.wr && host.ofs == `IOCD_OFS_DAC0LO;
	assign wr9 = host.wr && host.ofs == `IOCD_OFS_DAC0HI;
	assign wrA = host.wr && host.ofs == `IOCD_OFS_DAC1LO;
	assign wrB = host.wr && host.ofs == `IOCD_OFS_DAC1HI;
	assign wrF = host.wr && host.ofs == `IOCD_OFS_CTRCTL;
	assign wr13 = host.wr && host.ofs == `IOCD_OFS_AUXCTL;
	assign rd1 = host.rd && host.ofs == `IOCD_OFS_DIO;
	assign rd4 = host.rd && host.ofs == `IOCD_OFS_RDSTART;
	assign ctrHit = host.ofs >= `IOCD_OFS_CTR0 && host.ofs <= `IOCD_OFS_CTR2;
	assign auxHit = host.ofs >= `IOCD_OFS_AUXA && host.ofs <= `IOCD_OFS_AUXC;

	// Start trigger: select bit picks the source, offset 3 always starts
	assign startPulse = wr3
		|| (wr2 && !cardCmd[`IOCD_BIT_CSSEL])
		|| (rd4 && cardCmd[`IOCD_BIT_CSSEL]);

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ipS1_r <= 4'h0;
			ipS2_r <= 4'h0;
			opS1_r <= 4'h0;
			opS2_r <= 4'h0;
			discS1_r <= 2'h0;
			discS2_r <= 2'h0;
		end else begin
			ipS1_r <= discIn;
			ipS2_r <= ipS1_r;
			opS1_r <= opIn;
			opS2_r <= opS1_r;
			discS1_r <= {seMode, 1'b0};
			discS2_r <= discS1_r;
		end
	end

	// Card and converter command registers
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cardCmd <= `IOCD_RST_BYTE;
			cnvCmd <= `IOCD_RST_BYTE;
			seLatch_r <= `IOCD_RST_BYTE;
		end else begin
			if (wr0)
				cardCmd <= host.wdata;
			if (wr2) begin
				cnvCmd <= host.wdata;
				// Mode pin is captured on each converter command write
				seLatch_r <= {1'b0, discS2_r[1], 6'h00};
			end
		end
	end

	// Output port and its enables; enable high in the byte means drive
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			opOut <= 4'h0;
			opOe_n <= 4'hF;
		end else if (wr1) begin
			opOut <= host.wdata[3:0];
			opOe_n <= ~host.wdata[7:4];
		end
	end

	// Interrupt latch; a new event wins over the clearing read
	always_ff @(posedge clk) begin
		if (!rst_n)
			irqLatch <= 1'b0;
		else if (irqEvent)
			irqLatch <= 1'b1;
		else if (rd1)
			irqLatch <= 1'b0;
	end

	// Conversion start and busy; a start while busy is passed on but busy stays
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnvStart <= 1'b0;
			cnvBusy <= 1'b0;
		end else begin
			cnvStart <= startPulse;
			if (startPulse)
				cnvBusy <= 1'b1;
			else if (cnvEnd)
				cnvBusy <= 1'b0;
		end
	end

	// Result latch, held until the next conversion ends
	always_ff @(posedge clk) begin
		if (!rst_n)
			sample_r <= `IOCD_RST_SAMPLE;
		else if (cnvEnd)
			sample_r <= cnvData;
	end

	// DAC holding bytes and outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			dac0Lo_r <= `IOCD_RST_BYTE;
			dac1Lo_r <= `IOCD_RST_BYTE;
			dac0Out <= `IOCD_RST_DAC;
			dac1Out <= `IOCD_RST_DAC;
		end else begin
			if (wr8)
				dac0Lo_r <= host.wdata;
			if (wr9)
				dac0Out <= {host.wdata, dac0Lo_r[7:4]};
			if (wrA)
				dac1Lo_r <= host.wdata;
			if (wrB)
				dac1Out <= {host.wdata, dac1Lo_r[7:4]};
		end
	end

	// Forced zero: data registers and outputs keep their values, only the dacZero flag is set
	always_ff @(posedge clk) begin
		if (!rst_n)
			dacZero <= 1'b0;
		else if (wr4 || wr5)
			dacZero <= 1'b1;
		else if (wrB || wr9)
			dacZero <= 1'b0;
	end

	// Strobes to counter and aux devices, registered so outputs come from flops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrBus <= '0;
			auxBus <= '0;
			ctrCtlWr <= 1'b0;
			auxCtlWr <= 1'b0;
		end else begin
			ctrBus.rd <= host.rd && ctrHit;
			ctrBus.wr <= host.wr && ctrHit;
			ctrBus.idx <= 2'(host.ofs - `IOCD_OFS_CTR0);
			ctrBus.wdata <= host.wdata;
			ctrCtlWr <= wrF;
			auxBus.rd <= host.rd && auxHit;
			auxBus.wr <= host.wr && auxHit;
			auxBus.idx <= 2'(host.ofs - `IOCD_OFS_AUXA);
			auxBus.wdata <= host.wdata;
			auxCtlWr <= wr13;
		end
	end

	// Read data mux; unused and out-of-window reads give all ones
	always_comb begin
		rdData_nxt = `IOCD_UNUSED_RD;
		if (inRange) begin
			case (host.ofs)
				`IOCD_OFS_CMD: rdData_nxt = cardCmd;
				`IOCD_OFS_DIO: rdData_nxt = {ipS2_r, opS2_r};
				`IOCD_OFS_CNV: rdData_nxt = {cnvBusy, seLatch_r[`IOCD_BIT_SEMODE], cnvCmd[5:0]};
				`IOCD_OFS_SMPLO: rdData_nxt = {sample_r[3:0], 4'h0};
				`IOCD_OFS_SMPHI: rdData_nxt = sample_r[11:4];
				// Counter and aux reads pass straight through; devices answer combinationally
				`IOCD_OFS_CTR0, `IOCD_OFS_CTR1, `IOCD_OFS_CTR2: rdData_nxt = ctrRdData;
				`IOCD_OFS_AUXA, `IOCD_OFS_AUXB, `IOCD_OFS_AUXC: rdData_nxt = auxRdData;
				default: rdData_nxt = `IOCD_UNUSED_RD;
			endcase
		end
	end

	// Registered read data, one cycle after the read strobe
	always_ff @(posedge clk) begin
		if (!rst_n)
			rdData <= `IOCD_UNUSED_RD;
		else if (host.rd)
			rdData <= rdData_nxt;
	end

	// DAC outputs stay raw; the zero flag qualifies them downstream
	// Limitation: the analog side must honour dacZero, this block never gates the codes
endmodule
`default_nettype wire

/* verification/iocd_decode_asserts.sv */
/* Port checks on the I/O card decode.
 Assumes one clock domain and a bind onto iocd_decode. */
`timescale 1ns/1ps
`default_nettype none
module iocd_decode_asserts (
	// Clock, reset, host
	input wire logic clk,
	input wire logic rst_n,
	input wire iocd_pkg::iocd_host_t host,
	// Watched outputs
	input wire logic [7:0] rdData,
	input wire logic cnvStart,
	input wire logic cnvBusy,
	input wire logic dacZero,
	input wire logic irqEvent,
	input wire logic irqLatch,
	input wire logic [7:0] cardCmd,
	input wire iocd_pkg::iocd_sub_t ctrBus,
	input wire logic auxCtlWr
);
	import iocd_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Side effects land one cycle after the host cycle
	AST_WR3_START: assert property (host.wr && host.ofs == 5'h03 |=> cnvStart)
		else $error("no start after write 3");
	AST_WR2_START: assert property (host.wr && host.ofs == 5'h02 && !cardCmd[5] |=> cnvStart)
		else $error("no start after write 2");
	AST_RD4_START: assert property (host.rd && host.ofs == 5'h04 && cardCmd[5] |=> cnvStart)
		else $error("no start after read 4");
	AST_BUSY_SET: assert property (cnvStart |-> cnvBusy)
		else $error("busy low while starting");
	AST_DAC_ZERO: assert property (host.wr && (host.ofs == 5'h04 || host.ofs == 5'h05) |=> dacZero)
		else $error("dac not zeroed");
	AST_DAC_RELEASE: assert property (host.wr && host.ofs == 5'h0B |=> !dacZero)
		else $error("dac zero not released");
	AST_IRQ_CLEAR: assert property (host.rd && host.ofs == 5'h01 && !irqEvent |=> !irqLatch)
		else $error("irq latch not cleared");
	AST_UNUSED_READ: assert property (host.rd && host.ofs > 5'h13 |=> rdData == 8'hFF)
		else $error("unused read not ones");
	AST_CTR_LOAD: assert property (host.wr && host.ofs == 5'h0C |=>
		ctrBus.wr && ctrBus.idx == 2'h0 && ctrBus.wdata == $past(host.wdata))
		else $error("counter 0 load wrong");
	AST_AUX_CTL: assert property (host.wr && host.ofs == 5'h13 |=> auxCtlWr)
		else $error("aux control not strobed");
endmodule
bind iocd_decode iocd_decode_asserts CHK (.clk, .rst_n, .host, .rdData, .cnvStart, .cnvBusy,
	.dacZero, .irqEvent, .irqLatch, .cardCmd, .ctrBus, .auxCtlWr);
`default_nettype wire

/* verification/iocd_host_model.sv */
/* Host processor model doing byte I/O cycles.
 Assumes the decode takes one-cycle strobes on the rising edge. */
`timescale 1ns/1ps
`default_nettype none
module iocd_host_model (
	// Clock and read data
	input wire logic clk,
	input wire logic [7:0] rdData,
	// Host cycle
	output iocd_pkg::iocd_host_t host
);
	import iocd_pkg::*;
	initial host = '0;
	// Idle bus shows inverted data after a write and all ones after a read, not the last value
	task automatic io_wr(input logic [4:0] o, input logic [7:0] d);
		@(negedge clk) host <= {2'b01, o, d};
		@(negedge clk) host <= {2'b00, o, ~d};
	endtask
	task automatic io_rd(input logic [4:0] o, output logic [7:0] d);
		@(negedge clk) host <= {2'b10, o, 8'h00};
		@(negedge clk) host <= {2'b00, o, 8'hFF};
		d = rdData;
	endtask
	// Bounded wait for end of busy before the result is read
	task automatic poll(output logic [7:0] s);
		for (int i = 0; i < 40; i++) begin
			io_rd(5'h02, s);
			if (s[7] === 1'b0) break;
		end
	endtask
endmodule
`default_nettype wire

/* verification/tb.sv */
/* Self-checking bench for the I/O card decode.
 Assumes the host model and a simple converter stand-in. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import iocd_pkg::*;
	logic clk, rst_n, irqEvent, cnvEnd, seMode, irqLatch, cnvStart, cnvBusy, dacZero, auxCtlWr;
	logic [3:0] discIn, opIn, cd, opOut, opOe_n;
	logic [11:0] cnvData, dac0Out, dac1Out;
	logic [7:0] rdData, cardCmd, cnvCmd, ctrRdData, auxRdData, v;
	iocd_host_t host;
	int errors, samples_checked, cyc;
	iocd_decode DUT (.clk, .rst_n, .host, .rdData, .discIn, .opIn, .opOut, .opOe_n, .irqEvent,
		.irqLatch, .cnvEnd, .cnvData, .seMode, .cnvStart, .cnvBusy, .cardCmd, .cnvCmd, .dac0Out,
		.dac1Out, .dacZero, .ctrRdData, .auxRdData, .ctrBus(), .ctrCtlWr(), .auxBus(), .auxCtlWr);
	iocd_host_model HOST (.clk, .rdData, .host);
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	// Converter stand-in: ends a conversion six cycles after its start
	always @(negedge clk) begin
		if (!rst_n) begin
			cnvEnd <= 1'b0;
			cd <= 4'h0;
		end else begin
			cnvEnd <= (cd == 4'h1);
			cd <= cnvStart ? 4'h6 : (cd != 4'h0 ? cd - 4'h1 : 4'h0);
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 4000) begin
			errors++;
			finish_test;
		end
	end
	task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task finish_test;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task t_unused;
		HOST.io_wr(5'h06, 8'h55);
		HOST.io_rd(5'h14, v);
		chk("rd14", 8'hFF, v);
		HOST.io_rd(5'h05, v);
		chk("rd05", 8'hFF, v);
	endtask
	task t_select_low;
		cnvData = 12'h9C3;
		HOST.io_wr(5'h00, 8'h00);
		HOST.io_wr(5'h02, 8'h05);
		HOST.poll(v);
		chk("busy", 12'h0, v[7]);
		HOST.io_rd(5'h06, v);
		chk("low", 8'h30, v);
		HOST.io_rd(5'h07, v);
		chk("high", 8'h9C, v);
	endtask
	task t_select_high;
		cnvData = 12'h5A7;
		HOST.io_wr(5'h00, 8'h20);
		HOST.io_rd(5'h00, v);
		chk("cmd", 8'h20, v);
		HOST.io_wr(5'h02, 8'h01);
		chk("nostart", 12'h0, cnvBusy);
		chk("cnvcmd", 12'h01, cnvCmd);
		HOST.io_rd(5'h02, v);
		chk("cnvstat", 8'h01, v);
		HOST.io_rd(5'h04, v);
		HOST.poll(v);
		HOST.io_rd(5'h07, v);
		chk("high4", 8'h5A, v);
		cnvData = 12'h123;
		HOST.io_wr(5'h03, 8'hEE);
		chk("start3", 12'h1, cnvBusy);
		HOST.poll(v);
		HOST.io_rd(5'h07, v);
		chk("high3", 8'h12, v);
	endtask
	task t_dac;
		HOST.io_wr(5'h08, 8'hA0);
		HOST.io_wr(5'h04, 8'h00);
		chk("zero4", 12'h1, dacZero);
		HOST.io_wr(5'h09, 8'h5C);
		chk("dac0", 12'h5CA, dac0Out);
		HOST.io_wr(5'h0A, 8'h30);
		HOST.io_wr(5'h05, 8'h00);
		chk("zero5", 12'h1, dacZero);
		HOST.io_wr(5'h0B, 8'h12);
		chk("dac1", 12'h123, dac1Out);
		chk("unzero", 12'h0, dacZero);
	endtask
	task t_irq_sub;
		@(negedge clk) irqEvent <= 1'b1;
		@(negedge clk) irqEvent <= 1'b0;
		chk("irqset", 12'h1, irqLatch);
		HOST.io_rd(5'h01, v);
		chk("dio", 8'hA5, v);
		chk("irqclr", 12'h0, irqLatch);
		HOST.io_wr(5'h01, 8'h3A);
		chk("opout", 12'hA, opOut);
		chk("opoe", 12'hC, opOe_n);
		HOST.io_wr(5'h0C, 8'h11);
		HOST.io_wr(5'h0F, 8'h36);
		HOST.io_wr(5'h10, 8'h7E);
		HOST.io_wr(5'h13, 8'h80);
		HOST.io_rd(5'h0D, v);
		chk("ctr", 8'h3C, v);
		HOST.io_rd(5'h11, v);
		chk("aux", 8'hC3, v);
	endtask
	initial begin
		{rst_n, irqEvent, seMode, cnvData} = '0;
		{discIn, opIn, ctrRdData, auxRdData} = 24'hA53CC3;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		t_unused;
		t_select_low;
		t_select_high;
		t_dac;
		t_irq_sub;
		finish_test;
	end
endmodule
`default_nettype wire
